// *** logic/sta_pkg.sv ***
// Shared constants and carrier types for the stream timing adapter.
// Assumes one clock domain and a plain register port on the adapter.
package sta_pkg;

  // ---------------------------------------------------------------
  // Stream payload layout
  // ---------------------------------------------------------------
  localparam int STA_DATA_W = 32;
  localparam int STA_CHAN_W = 8;
  localparam int STA_EMPTY_W = 2;
  localparam int STA_MAX_RL = 8;

  // Everything except ready and valid travels as this word
  typedef struct packed {
    logic [STA_DATA_W-1:0] data;
    logic [STA_CHAN_W-1:0] channel;
    logic sop;
    logic eop;
    logic [STA_EMPTY_W-1:0] empty;
    logic error;
  } sta_pay_s;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int STA_ADDR_W = 4;
  localparam int STA_REG_W = 32;

  typedef struct packed {
    logic [STA_ADDR_W-1:0] addr;
    logic [STA_REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } sta_req_s;

  localparam logic [STA_ADDR_W-1:0] STA_OFF_STATUS = 4'h0;
  localparam logic [STA_ADDR_W-1:0] STA_OFF_MASK = 4'h1;
  localparam logic [STA_ADDR_W-1:0] STA_OFF_LOST = 4'h2;
  localparam logic [STA_ADDR_W-1:0] STA_OFF_LEVEL = 4'h3;
  localparam logic [STA_ADDR_W-1:0] STA_OFF_CONFIG = 4'h4;

  // Status and mask share this layout
  localparam int STA_EV_W = 2;
  localparam int STA_EV_LOST = 0;
  localparam int STA_EV_OVF = 1;

  // Configuration readback layout
  localparam int STA_CFG_IN_RDY = 0;
  localparam int STA_CFG_IN_VLD = 1;
  localparam int STA_CFG_OUT_RDY = 2;
  localparam int STA_CFG_OUT_VLD = 3;
  localparam int STA_CFG_IN_RL = 4;
  localparam int STA_CFG_OUT_RL = 8;

  // Reset values
  localparam logic [STA_EV_W-1:0] STA_STATUS_RST = 2'h0;
  localparam logic [STA_EV_W-1:0] STA_MASK_RST = 2'h0;
  localparam logic [15:0] STA_LOST_RST = 16'h0;

endpackage

// *** logic/sta_adapter.sv ***
// Stream timing adapter between one upstream source and one downstream sink.
// Assumes both cores share clk_sys and srst and the link is point to point.
`timescale 1ns/1ps

module sta_adapter
  import sta_pkg::*;
#(
  parameter bit IN_HAS_READY = 1'b1,
  parameter bit IN_HAS_VALID = 1'b1,
  parameter int unsigned IN_RL = 0,
  parameter bit OUT_HAS_READY = 1'b1,
  parameter bit OUT_HAS_VALID = 1'b1,
  parameter int unsigned OUT_RL = 0
)
(
  input wire logic clk_sys,
  input wire logic srst,
  // Sink port facing the upstream source
  input wire sta_pay_s in_pay,
  input wire logic in_valid,
  output logic in_ready,
  // Source port facing the downstream sink
  output sta_pay_s out_pay,
  output logic out_valid,
  input wire logic out_ready,
  // Loss indication
  output logic err_lost,
  // Register port
  input wire sta_req_s reg_req,
  output logic [STA_REG_W-1:0] reg_rdata,
  output logic irq
);

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  localparam bit BOTH_RDY = IN_HAS_READY && OUT_HAS_READY;
  localparam bit MODE_BUF = BOTH_RDY && (IN_RL > OUT_RL);
  localparam bit MODE_PIPE = BOTH_RDY && (OUT_RL > IN_RL);
  localparam bit MODE_LOSS = !IN_HAS_READY && OUT_HAS_READY;
  localparam int unsigned UP_D = MODE_PIPE ? OUT_RL - IN_RL : 0;
  localparam int unsigned BUF_D = MODE_BUF ? IN_RL - OUT_RL : 0;
  localparam logic [3:0] BUF_D4 = 4'(BUF_D);

  // ---------------------------------------------------------------
  // Ready history
  // ---------------------------------------------------------------
  logic [STA_MAX_RL-1:0] hist_q;
  logic [STA_MAX_RL-1:0] hist_d;
  logic [STA_MAX_RL:0] rhist;
  logic out_rdy_eff;
  logic sink_slot;
  logic in_v_eff;

  // Missing sink ready means the sink always takes data
  assign out_rdy_eff = OUT_HAS_READY ? out_ready : 1'b1;
  // Missing source valid means every cycle carries a word
  assign in_v_eff = IN_HAS_VALID ? in_valid : 1'b1;
  // Index k gives sink ready as it stood k cycles ago
  assign rhist = {hist_q, out_rdy_eff};
  // Sink accepts data now only if ready was up OUT_RL cycles ago
  assign sink_slot = rhist[OUT_RL];

  // Shift in the sink ready each cycle
  always_comb
  begin
    hist_d = {hist_q[STA_MAX_RL-2:0], out_rdy_eff};
    if (srst)
    begin
      hist_d = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    hist_q <= hist_d;
  end

  // ---------------------------------------------------------------
  // Compensation buffer
  // ---------------------------------------------------------------
  sta_pay_s mem_q [STA_MAX_RL];
  sta_pay_s mem_d [STA_MAX_RL];
  logic [2:0] wptr_q;
  logic [2:0] wptr_d;
  logic [2:0] rptr_q;
  logic [2:0] rptr_d;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic buf_push;
  logic buf_pop;
  logic buf_ovf;

  // Late words are held until a cycle the sink will accept them
  always_comb
  begin
    buf_pop = MODE_BUF && sink_slot && (count_q != 4'h0);
    buf_push = MODE_BUF && in_v_eff && !(sink_slot && (count_q == 4'h0));
    buf_ovf = buf_push && !buf_pop && (count_q == BUF_D4);
    mem_d = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    count_d = count_q;
    if (buf_push && !buf_ovf)
    begin
      mem_d[wptr_q] = in_pay;
      wptr_d = wptr_q + 3'h1;
    end
    if (buf_pop)
    begin
      rptr_d = rptr_q + 3'h1;
    end
    if ((buf_push && !buf_ovf) && !buf_pop)
    begin
      count_d = count_q + 4'h1;
    end
    else if (buf_pop && !(buf_push && !buf_ovf))
    begin
      count_d = count_q - 4'h1;
    end
    if (srst)
    begin
      wptr_d = 3'h0;
      rptr_d = 3'h0;
      count_d = 4'h0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    mem_q <= mem_d;
    wptr_q <= wptr_d;
    rptr_q <= rptr_d;
    count_q <= count_d;
  end

  // ---------------------------------------------------------------
  // Forward path and ready path
  // ---------------------------------------------------------------
  logic fwd_v;

  // Buffered words leave first; otherwise the source word passes through
  always_comb
  begin
    if (MODE_BUF)
    begin
      out_pay = (count_q != 4'h0) ? mem_q[rptr_q] : in_pay;
      fwd_v = sink_slot && ((count_q != 4'h0) || in_v_eff);
    end
    else
    begin
      out_pay = in_pay;
      fwd_v = in_v_eff;
    end
    // A valid-less sink takes the bare payload; the pin is tied
    out_valid = OUT_HAS_VALID ? fwd_v : 1'b0;
  end

  // Ready toward the source for each configuration
  always_comb
  begin
    if (!IN_HAS_READY)
    begin
      in_ready = 1'b0;
    end
    else if (!OUT_HAS_READY)
    begin
      in_ready = 1'b1;
    end
    else if (MODE_PIPE)
    begin
      in_ready = rhist[UP_D];
    end
    else
    begin
      in_ready = out_rdy_eff;
    end
  end

  // ---------------------------------------------------------------
  // Loss detection and registers
  // ---------------------------------------------------------------
  logic lost_ev;
  logic err_q;
  logic err_d;
  logic [STA_EV_W-1:0] status_q;
  logic [STA_EV_W-1:0] status_d;
  logic [STA_EV_W-1:0] mask_q;
  logic [STA_EV_W-1:0] mask_d;
  logic [15:0] lostcnt_q;
  logic [15:0] lostcnt_d;
  logic [STA_REG_W-1:0] rdata_q;
  logic [STA_REG_W-1:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [STA_EV_W-1:0] ev;
  logic [STA_REG_W-1:0] cfg_word;

  // A word offered while the sink cannot take it is gone
  assign lost_ev = MODE_LOSS && in_v_eff && !sink_slot;
  assign ev = {buf_ovf, lost_ev};

  // Configuration readback word
  always_comb
  begin
    cfg_word = '0;
    cfg_word[STA_CFG_IN_RDY] = IN_HAS_READY;
    cfg_word[STA_CFG_IN_VLD] = IN_HAS_VALID;
    cfg_word[STA_CFG_OUT_RDY] = OUT_HAS_READY;
    cfg_word[STA_CFG_OUT_VLD] = OUT_HAS_VALID;
    cfg_word[STA_CFG_IN_RL +: 4] = 4'(IN_RL);
    cfg_word[STA_CFG_OUT_RL +: 4] = 4'(OUT_RL);
  end

  // Status clears on read, new events win; mask gates the interrupt
  always_comb
  begin
    err_d = lost_ev;
    status_d = status_q;
    if (reg_req.rd && (reg_req.addr == STA_OFF_STATUS))
    begin
      status_d = '0;
    end
    status_d = status_d | ev;
    mask_d = mask_q;
    if (reg_req.wr && (reg_req.addr == STA_OFF_MASK))
    begin
      mask_d = reg_req.wdata[STA_EV_W-1:0];
    end
    lostcnt_d = lost_ev ? lostcnt_q + 16'h1 : lostcnt_q;
    rdata_d = '0;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        STA_OFF_STATUS: rdata_d[STA_EV_W-1:0] = status_q;
        STA_OFF_MASK: rdata_d[STA_EV_W-1:0] = mask_q;
        STA_OFF_LOST: rdata_d[15:0] = lostcnt_q;
        STA_OFF_LEVEL: rdata_d[3:0] = count_q;
        STA_OFF_CONFIG: rdata_d = cfg_word;
        default: rdata_d = '0;
      endcase
    end
    irq_d = |(status_d & mask_d);
    if (srst)
    begin
      err_d = 1'b0;
      status_d = STA_STATUS_RST;
      mask_d = STA_MASK_RST;
      lostcnt_d = STA_LOST_RST;
      rdata_d = '0;
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    err_q <= err_d;
    status_q <= status_d;
    mask_q <= mask_d;
    lostcnt_q <= lostcnt_d;
    rdata_q <= rdata_d;
    irq_q <= irq_d;
  end

  assign err_lost = err_q;
  assign reg_rdata = rdata_q;
  assign irq = irq_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_lost;
    lost_ev;
  endsequence

  sequence s_flagged;
    err_lost && status_q[STA_EV_LOST];
  endsequence

  property p_rdy_tied;
    @(posedge clk_sys) disable iff (srst)
    (IN_HAS_READY && !OUT_HAS_READY) |-> in_ready;
  endproperty
  a_rdy_tied: assert property (p_rdy_tied) else $error("source ready not held high");

  property p_lost_flag;
    @(posedge clk_sys) disable iff (srst)
    s_lost |=> s_flagged;
  endproperty
  a_lost_flag: assert property (p_lost_flag) else $error("lost word not flagged");

  property p_no_false_loss;
    @(posedge clk_sys) disable iff (srst)
    (MODE_LOSS && (!in_v_eff || sink_slot)) |=> !err_lost;
  endproperty
  a_no_false_loss: assert property (p_no_false_loss) else $error("loss flagged without loss");

  property p_payload;
    @(posedge clk_sys) disable iff (srst)
    !MODE_BUF |-> (out_pay == in_pay);
  endproperty
  a_payload: assert property (p_payload) else $error("payload altered");

  property p_valid_high;
    @(posedge clk_sys) disable iff (srst)
    (!IN_HAS_VALID && OUT_HAS_VALID && !MODE_BUF) |-> out_valid;
  endproperty
  a_valid_high: assert property (p_valid_high) else $error("sink valid not held high");

  property p_buf_cap;
    @(posedge clk_sys) disable iff (srst)
    MODE_BUF |-> (count_q <= BUF_D4);
  endproperty
  a_buf_cap: assert property (p_buf_cap) else $error("buffer past its depth");

  property p_buf_slot;
    @(posedge clk_sys) disable iff (srst)
    (MODE_BUF && out_valid) |-> sink_slot;
  endproperty
  a_buf_slot: assert property (p_buf_slot) else $error("buffer drove outside sink slot");

  property p_buf_reset;
    @(posedge clk_sys) disable iff (srst)
    $past(srst) |-> (count_q == 4'h0);
  endproperty
  a_buf_reset: assert property (p_buf_reset) else $error("buffer not empty after reset");

  property p_irq;
    @(posedge clk_sys) disable iff (srst)
    (s_lost ##0 mask_q[STA_EV_LOST] && !reg_req.wr) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing after loss");

  generate
    if (MODE_PIPE)
    begin : g_pipe_chk
      property p_rdy_delay;
        @(posedge clk_sys) disable iff (srst)
        ##UP_D 1'b1 |-> (in_ready == $past(out_ready, UP_D));
      endproperty
      a_rdy_delay: assert property (p_rdy_delay) else $error("ready delay wrong");
    end
  endgenerate

endmodule

// *** tb/sta_sink_model.sv ***
// Downstream sink model for the stream timing adapter.
// Assumes zero ready latency and the clock and reset of the adapter.
`timescale 1ns/1ps

module sta_sink_model
  import sta_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic stall,
  input wire sta_pay_s out_pay,
  input wire logic out_valid,
  output logic out_ready,
  output logic [7:0] got_cnt,
  output sta_pay_s got_pay
);
  // Ready follows the stall request with no delay
  assign out_ready = ~stall;

  // Capture each word taken in a ready cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      got_cnt <= 8'h00;
      got_pay <= '0;
    end
    else if (out_valid && out_ready)
    begin
      got_cnt <= got_cnt + 8'h01;
      got_pay <= out_pay;
    end
  end
endmodule

// *** tb/sta_adapter_tb_top.sv ***
// Self-checking bench for the stream timing adapter.
// Assumes four instances: ready-less source, two-cycle ready skew, two-cycle buffer and valid-less source.
`timescale 1ns/1ps

module sta_adapter_tb_top
  import sta_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam sta_pay_s TB_PAY = '{data: 32'hcafe0001, channel: 8'h5a, sop: 1'b1, eop: 1'b0,
                                  empty: 2'h3, error: 1'b1};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  sta_pay_s pay = '0;
  logic in_valid = 1'b0;
  logic stall = 1'b0;
  logic p_rdy = 1'b0;
  sta_req_s req = '0;
  sta_pay_s out_pay;
  sta_pay_s got_pay;
  logic out_valid, out_ready, in_ready, err_lost, irq, p_in_ready;
  logic [STA_REG_W-1:0] rdata;
  logic [7:0] got_cnt;
  sta_pay_s b_pay = '0;
  sta_pay_s b_out;
  sta_pay_s f_out;
  logic b_rdy = 1'b1;
  logic b_vld = 1'b0;
  logic b_vout, b_in_ready, f_in_ready, f_out_valid, p_out_valid;
  logic [STA_REG_W-1:0] b_rdata;
  int errors = 0;
  int tests_run = 0;

  // Clock toggles every half period
  always #5 clk_sys = ~clk_sys;

  sta_adapter #(.IN_HAS_READY(1'b0)) sta_adapter_i (.clk_sys(clk_sys), .srst(srst), .in_pay(pay),
    .in_valid(in_valid), .in_ready(in_ready), .out_pay(out_pay), .out_valid(out_valid),
    .out_ready(out_ready), .err_lost(err_lost), .reg_req(req), .reg_rdata(rdata), .irq(irq));
  sta_adapter #(.OUT_RL(2), .OUT_HAS_VALID(1'b0)) sta_adapter_pipe_i (.clk_sys(clk_sys), .srst(srst), .in_pay(pay),
    .in_valid(in_valid), .in_ready(p_in_ready), .out_pay(), .out_valid(p_out_valid), .out_ready(p_rdy),
    .err_lost(), .reg_req(req), .reg_rdata(), .irq());
  sta_adapter #(.IN_RL(2)) sta_adapter_buf_i (.clk_sys(clk_sys), .srst(srst), .in_pay(b_pay),
    .in_valid(b_vld), .in_ready(b_in_ready), .out_pay(b_out), .out_valid(b_vout), .out_ready(b_rdy),
    .err_lost(), .reg_req(req), .reg_rdata(b_rdata), .irq());
  sta_adapter #(.IN_HAS_VALID(1'b0), .OUT_HAS_READY(1'b0)) sta_adapter_free_i (.clk_sys(clk_sys), .srst(srst),
    .in_pay(pay), .in_valid(in_valid), .in_ready(f_in_ready), .out_pay(f_out), .out_valid(f_out_valid),
    .out_ready(out_ready), .err_lost(), .reg_req(req), .reg_rdata(), .irq());
  // The sink model serves sta_adapter_i only; sta_adapter_free_i shares its ready, and three instances share pay and in_valid
  sta_sink_model sta_sink_model_i (.clk_sys(clk_sys), .srst(srst), .stall(stall), .out_pay(out_pay),
    .out_valid(out_valid), .out_ready(out_ready), .got_cnt(got_cnt), .got_pay(got_pay));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle register write
  task automatic reg_wr(input logic [STA_ADDR_W-1:0] a, input logic [STA_REG_W-1:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // One-cycle register read, data judged in the following cycle
  task automatic reg_rd(input logic [STA_ADDR_W-1:0] a, input logic [STA_REG_W-1:0] exp);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 check(rdata, exp);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, readback, unmapped and read-only places
  task automatic t_reset();
    reg_rd(STA_OFF_STATUS, 32'h0);
    reg_rd(STA_OFF_MASK, 32'h0);
    reg_rd(STA_OFF_LOST, 32'h0);
    reg_rd(STA_OFF_LEVEL, 32'h0);
    reg_rd(STA_OFF_CONFIG, 32'h0000000e);
    reg_rd(4'hf, 32'h0);
    reg_wr(STA_OFF_LOST, 32'h0000ffff);
    reg_rd(STA_OFF_LOST, 32'h0);
    reg_wr(STA_OFF_MASK, 32'h00000003);
    reg_rd(STA_OFF_MASK, 32'h00000003);
    check(irq, 1'b0);
  endtask

  // Payload and valid pass straight through to a ready sink
  task automatic t_pass();
    @(posedge clk_sys);
    pay <= TB_PAY;
    in_valid <= 1'b1;
    #1 check(out_pay, TB_PAY);
    check(out_valid, 1'b1);
    check(in_ready, 1'b0);
    check(f_out, TB_PAY);
    check(p_out_valid, 1'b0);
    @(posedge clk_sys);
    in_valid <= 1'b0;
    #1 check(out_valid, 1'b0);
    check(f_out_valid, 1'b1);
    check(got_cnt, 8'h01);
    check(got_pay, TB_PAY);
    check(err_lost, 1'b0);
  endtask

  // A word offered to a stalled sink is lost and flagged
  task automatic t_loss(input logic mask_on, input logic [15:0] exp_cnt);
    reg_wr(STA_OFF_MASK, {31'h0, mask_on});
    @(posedge clk_sys);
    stall <= 1'b1;
    in_valid <= 1'b1;
    #1 check(f_in_ready, 1'b1);
    check(f_out_valid, 1'b1);
    @(posedge clk_sys);
    stall <= 1'b0;
    in_valid <= 1'b0;
    #1 check(err_lost, 1'b1);
    @(posedge clk_sys);
    #1 check(err_lost, 1'b0);
    check(irq, mask_on);
    check(got_cnt, 8'h01);
    reg_rd(STA_OFF_LOST, {16'h0, exp_cnt});
    reg_rd(STA_OFF_STATUS, 32'h00000001);
    @(posedge clk_sys);
    #1 check(irq, 1'b0);
    reg_rd(STA_OFF_STATUS, 32'h0);
  endtask

  // Ready reaches the source two cycles after the sink raises or drops it
  task automatic t_pipe();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      p_rdy <= (i < 3);
      #1 check(p_in_ready, (i >= 2) && (i < 5));
    end
  endtask

  // Sink ready drops; words the slower source still sends wait in the buffer, a third one overflows
  task automatic t_buf();
    for (int c = 0; c < 10; c++)
    begin
      @(posedge clk_sys);
      b_rdy <= (c < 2) || (c >= 4 && c < 7);
      b_vld <= (c >= 2 && c < 4) || (c >= 6);
      b_pay.data <= 32'(c);
      #1 check(b_in_ready, (c < 2) || (c >= 4 && c < 7));
      check(b_vout, (c >= 4 && c < 7));
      if (c >= 4 && c < 7) check(b_out.data, (c == 6) ? 32'h6 : 32'(c - 2));
    end
    @(posedge clk_sys);
    b_vld <= 1'b0;
    b_rdy <= 1'b1;
    req <= '{addr: STA_OFF_STATUS, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    #1 check(b_vout, 1'b1);
    check(b_out.data, 32'h7);
    @(posedge clk_sys);
    req <= '0;
    #1 check(b_rdata, 32'h2);
    check(b_out.data, 32'h8);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_pass();
    t_loss(1'b0, 16'h0001);
    t_loss(1'b1, 16'h0002);
    t_pipe();
    t_buf();
    give_verdict();
  end

  // Cuts a hang short well beyond the expected run
  initial
  begin
    #20000;
    errors++;
    give_verdict();
  end
endmodule
